//--- pkg/uicr_pkg.sv
// shared constants for the interrupt clear register bank
package uicr_pkg;
  localparam int          ADDR_W        = 12;
  localparam int          DATA_W        = 32;
  localparam int          NSRC          = 7;
  // source index 0..6 maps to register bits 4..10
  localparam int          SRC_LSB       = 4;
  localparam int          BIT_RX        = 4;
  localparam int          BIT_TX        = 5;
  localparam int          BIT_RT        = 6;
  localparam int          BIT_FE        = 7;
  localparam int          BIT_PE        = 8;
  localparam int          BIT_BE        = 9;
  localparam int          BIT_OE        = 10;
  localparam logic [11:0] OFS_RAW       = 12'h03c;
  localparam logic [11:0] OFS_MASKED    = 12'h040;
  localparam logic [11:0] OFS_CLEAR     = 12'h044;
  localparam logic [11:0] OFS_ENABLE    = 12'h038;
  localparam logic [31:0] RST_VAL       = 32'h0000_0000;
  localparam logic [6:0]  RST_SRC       = 7'h00;
endpackage : uicr_pkg

//--- hdl/uicr_src_latch.sv
// one sticky raw interrupt latch with write-one clear
module uicr_src_latch
  import uicr_pkg::*;
(
  input  wire logic ref_clk_i,
  input  wire logic rst_i,
  input  wire logic set_i,
  input  wire logic clr_i,
  output logic      raw_o
);
  logic raw_q;
  logic raw_d;

  // a new event in the clear cycle survives
  assign raw_d = set_i | (raw_q & ~clr_i);

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      raw_q <= 1'b0;
    end else begin
      raw_q <= raw_d;
    end
  end

  assign raw_o = raw_q;
endmodule : uicr_src_latch

//--- hdl/uicr_top.sv
// interrupt clear register bank with raw, enable and masked status
module uicr_top
  import uicr_pkg::*;
(
  input  wire logic              ref_clk_i,
  input  wire logic              rst_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  input  wire logic [NSRC-1:0]   src_event_i,
  output logic      [DATA_W-1:0] rdata_o,
  output logic      [NSRC-1:0]   src_clear_o,
  output logic                   irq_o
);
  logic [NSRC-1:0]   raw;
  logic [NSRC-1:0]   clr_hit;
  logic [NSRC-1:0]   enable_q;
  logic [NSRC-1:0]   enable_d;
  logic [NSRC-1:0]   masked;
  logic [NSRC-1:0]   clear_q;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;
  logic              irq_q;
  logic              sel_clear;
  logic              sel_enable;
  logic              sel_raw;
  logic              sel_masked;
  logic              wr_clear;
  logic [DATA_W-1:0] word_raw;
  logic [DATA_W-1:0] word_masked;
  logic [DATA_W-1:0] word_enable;

  assign sel_clear  = (addr_i == OFS_CLEAR);
  assign sel_enable = (addr_i == OFS_ENABLE);
  assign sel_raw    = (addr_i == OFS_RAW);
  assign sel_masked = (addr_i == OFS_MASKED);
  assign wr_clear   = wr_i & sel_clear;
  // only ones clear, zeros and bits 3:0 are ignored
  assign clr_hit  = wr_clear ? wdata_i[BIT_OE:SRC_LSB] : RST_SRC;
  assign enable_d = (wr_i & sel_enable) ? wdata_i[BIT_OE:SRC_LSB] : enable_q;
  assign masked   = raw & enable_q;

  genvar g;
  generate
    for (g = 0; g < NSRC; g++) begin : g_src
      // bits 4..10: rx, tx, rt, fe, pe, be, oe
      uicr_src_latch u_latch (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .set_i     (src_event_i[g]),
        .clr_i     (clr_hit[g]),
        .raw_o     (raw[g])
      );
    end
  endgenerate

  // status words share the clear layout, reserved bits zero
  assign word_raw    = {21'h00_0000, raw, 4'h0};
  assign word_masked = {21'h00_0000, masked, 4'h0};
  assign word_enable = {21'h00_0000, enable_q, 4'h0};

  // clear register reads 0; unmapped reads 0
  assign rdata_d = !rd_i      ? RST_VAL :
                   sel_raw    ? word_raw :
                   sel_masked ? word_masked :
                   sel_enable ? word_enable :
                   RST_VAL;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      enable_q <= RST_SRC;
      clear_q  <= RST_SRC;
      rdata_q  <= RST_VAL;
      irq_q    <= 1'b0;
    end else begin
      enable_q <= enable_d;
      clear_q  <= clr_hit;
      rdata_q  <= rdata_d;
      irq_q    <= |(((src_event_i | (raw & ~clr_hit))) & enable_d);
    end
  end

  assign rdata_o     = rdata_q;
  assign src_clear_o = clear_q;
  assign irq_o       = irq_q;

  AST_FE_CLEAR: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    wr_clear && wdata_i[BIT_FE] && !src_event_i[BIT_FE-SRC_LSB]
    |=> !raw[BIT_FE-SRC_LSB])
    else $error("framing source not cleared");

  AST_RT_CLEAR: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    wr_clear && wdata_i[BIT_RT] && !src_event_i[BIT_RT-SRC_LSB]
    |=> !raw[BIT_RT-SRC_LSB])
    else $error("timeout source not cleared");

  AST_TX_CLEAR: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    wr_clear && wdata_i[BIT_TX] && !src_event_i[BIT_TX-SRC_LSB]
    |=> !raw[BIT_TX-SRC_LSB])
    else $error("transmit source not cleared");

  AST_RX_CLEAR: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    wr_clear && wdata_i[BIT_RX] && !src_event_i[BIT_RX-SRC_LSB]
    |=> !raw[BIT_RX-SRC_LSB])
    else $error("receive source not cleared");

  AST_ZERO_KEEPS: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    wr_clear |=> ((raw ^ ($past(raw) | $past(src_event_i)))
                  & ~$past(wdata_i[BIT_OE:SRC_LSB])) == RST_SRC)
    else $error("zero bit disturbed a source");

  AST_BE_PE_CLEAR: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    wr_clear && wdata_i[BIT_BE] && wdata_i[BIT_PE] && src_event_i == RST_SRC
    |=> !raw[BIT_BE-SRC_LSB] && !raw[BIT_PE-SRC_LSB])
    else $error("break or parity not cleared");

  AST_MASKED_DROP: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    wr_clear && wdata_i[BIT_OE:SRC_LSB] == 7'h7f && src_event_i == RST_SRC
    |=> masked == RST_SRC && !irq_o)
    else $error("masked status or irq survived clear");

  AST_MASKED_BITS: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    wr_clear |=> (masked & $past(wdata_i[BIT_OE:SRC_LSB])
                  & ~$past(src_event_i)) == RST_SRC)
    else $error("masked bit survived its clear");

  AST_READ_ZERO: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    rd_i && sel_clear |=> rdata_o == RST_VAL)
    else $error("clear register read nonzero");

  AST_OE_CLEAR: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    wr_clear && wdata_i[BIT_OE] && !src_event_i[BIT_OE-SRC_LSB]
    |=> !raw[BIT_OE-SRC_LSB])
    else $error("overrun source not cleared");

  AST_SET_WINS: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    src_event_i[0] |=> raw[0])
    else $error("event lost");

  AST_IRQ_LEVEL: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    irq_o == (masked != RST_SRC))
    else $error("irq does not follow masked status");

  AST_CLEAR_ECHO: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    wr_clear |=> src_clear_o == $past(wdata_i[BIT_OE:SRC_LSB]))
    else $error("clear strobes differ from written ones");

  AST_CLEAR_IDLE: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    !wr_clear |=> src_clear_o == RST_SRC)
    else $error("clear strobe without a clear write");

  AST_ENABLE_LOAD: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    wr_i && sel_enable |=> enable_q == $past(wdata_i[BIT_OE:SRC_LSB]))
    else $error("enable write not taken");

  AST_ENABLE_KEEP: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    !(wr_i && sel_enable) |=> enable_q == $past(enable_q))
    else $error("enable changed without its write");

  AST_RDATA_IDLE: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    !rd_i |=> rdata_o == RST_VAL)
    else $error("read data outside its cycle");

  AST_RSVD_ZERO: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    rdata_o[DATA_W-1:BIT_OE+1] == 21'h00_0000
    && rdata_o[SRC_LSB-1:0] == 4'h0)
    else $error("reserved read bits nonzero");

  AST_RAW_READ: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    rd_i && sel_raw |=> rdata_o == $past(word_raw))
    else $error("raw status read wrong");

  AST_MASKED_READ: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    rd_i && sel_masked |=> rdata_o == $past(word_masked))
    else $error("masked status read wrong");

  AST_ENABLE_READ: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    rd_i && sel_enable |=> rdata_o == $past(word_enable))
    else $error("enable read wrong");

  AST_RD_NO_CLEAR: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    rd_i |=> src_clear_o == RST_SRC)
    else $error("read produced a clear strobe");

  // per source: hold without cause, set wins, clear works
  generate
    for (g = 0; g < NSRC; g++) begin : g_chk
      AST_SRC_HOLD: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        !src_event_i[g] && !clr_hit[g] |=> raw[g] == $past(raw[g]))
        else $error("source moved with no event or clear");

      AST_SRC_SET: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        src_event_i[g] |=> raw[g])
        else $error("event lost against a clear");

      AST_SRC_CLEAR: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        clr_hit[g] && !src_event_i[g] |=> !raw[g])
        else $error("clear strobe left its source set");
    end
  endgenerate

  // main scenarios
  COV_CLEAR_ONE: cover property (@(posedge ref_clk_i) disable iff (rst_i)
    raw[0] ##1 wr_clear && wdata_i[BIT_RX] ##1 !raw[0]);
  COV_IRQ: cover property (@(posedge ref_clk_i) disable iff (rst_i)
    irq_o ##1 wr_clear ##2 !irq_o);
  COV_RACE: cover property (@(posedge ref_clk_i) disable iff (rst_i)
    wr_clear && wdata_i[BIT_TX] && src_event_i[1]);
  COV_READ_BACK: cover property (@(posedge ref_clk_i) disable iff (rst_i)
    wr_clear ##2 rd_i && sel_raw);
  COV_IRQ_MASKED: cover property (@(posedge ref_clk_i) disable iff (rst_i)
    raw != RST_SRC && enable_q == RST_SRC && !irq_o);
endmodule : uicr_top

//--- verif/tb_uicr_top.sv
// self-checking bench for the interrupt clear register bank
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin \
  n_mismatch++; $display("BAD %0t got %h want %h", $time, (a), (b)); end end

module tb_uicr_top
  import uicr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic              ref_clk_i;
  logic              rst_i;
  logic [ADDR_W-1:0] addr_i;
  logic [DATA_W-1:0] wdata_i;
  logic              wr_i;
  logic              rd_i;
  logic [NSRC-1:0]   src_event_i;
  logic [DATA_W-1:0] rdata_o;
  logic [NSRC-1:0]   src_clear_o;
  logic              irq_o;
  logic [NSRC-1:0]   exp_q;
  int                n_mismatch;
  int                checks_done;

  uicr_top i_uicr_top (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .src_event_i(src_event_i), .rdata_o(rdata_o),
    .src_clear_o(src_clear_o), .irq_o(irq_o));

  initial begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end

  // source vector placed at register bits 10:4
  function automatic logic [31:0] sh(input logic [6:0] s);
    return {21'h00_0000, s, 4'h0};
  endfunction : sh

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge ref_clk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1 `CHK(rdata_o, e)
  endtask : rd

  task automatic ev(input logic [6:0] s);
    @(posedge ref_clk_i);
    src_event_i <= s;
    @(posedge ref_clk_i);
    src_event_i <= 7'h00;
  endtask : ev

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_of_test

  initial begin
    n_mismatch = 0;
    checks_done = 0;
    rst_i = 1'b1;
    addr_i = '0;
    wdata_i = '0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    src_event_i = '0;
    repeat (3) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    rd(OFS_RAW, RST_VAL);
    rd(OFS_ENABLE, RST_VAL);
    rd(OFS_MASKED, RST_VAL);
    ev(7'h7f);
    rd(OFS_RAW, sh(7'h7f));
    rd(OFS_MASKED, RST_VAL);
    `CHK(irq_o, 1'b0)
    wr(OFS_ENABLE, sh(7'h7f));
    @(posedge ref_clk_i);
    #1 `CHK(irq_o, 1'b1)
    exp_q = 7'h7f;
    for (int i = 0; i < NSRC; i++) begin
      wr(OFS_CLEAR, 32'h0000_0001 << (SRC_LSB + i));
      `CHK(src_clear_o, 7'h01 << i)
      exp_q[i] = 1'b0;
      rd(OFS_RAW, sh(exp_q));
      rd(OFS_MASKED, sh(exp_q));
      `CHK(src_clear_o, 7'h00)
    end
    `CHK(irq_o, 1'b0)
    ev(7'h7f);
    rd(OFS_CLEAR, RST_VAL);
    wr(OFS_CLEAR, RST_VAL);
    `CHK(src_clear_o, 7'h00)
    wr(12'h100, sh(7'h7f));
    rd(12'h100, RST_VAL);
    rd(OFS_RAW, sh(7'h7f));
    wr(OFS_CLEAR, sh(7'h7f));
    `CHK(src_clear_o, 7'h7f)
    rd(OFS_RAW, RST_VAL);
    `CHK(irq_o, 1'b0)
    wr(OFS_ENABLE, RST_VAL);
    ev(7'h01);
    repeat (2) @(posedge ref_clk_i);
    #1 `CHK(irq_o, 1'b0)
    rd(OFS_MASKED, RST_VAL);
    rd(OFS_RAW, sh(7'h01));
    wr(OFS_ENABLE, sh(7'h7f));
    @(posedge ref_clk_i);
    wr_i        <= 1'b1;
    addr_i      <= OFS_CLEAR;
    wdata_i     <= sh(7'h03);
    src_event_i <= 7'h02;
    @(posedge ref_clk_i);
    wr_i        <= 1'b0;
    src_event_i <= 7'h00;
    #1 `CHK(src_clear_o, 7'h03)
    `CHK(irq_o, 1'b1)
    rd(OFS_RAW, sh(7'h02));
    @(posedge ref_clk_i);
    #1 `CHK(rdata_o, RST_VAL)
    end_of_test();
  end
endmodule : tb_uicr_top
